// ### hdl/src_supervisor.v
// Implementation choices: the address map and register access over Avalon-MM.
`include "src_consts.vh"

module src_supervisor #(
  parameter STRETCH_CYCLES = `SRC_STRETCH_MS * `SRC_STRETCH_REF_KHZ,
  parameter STRETCH_W      = 20,
  parameter WD_W           = 24
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        reset_pin_n,
  input  wire        low_voltage_in,
  input  wire        debug_reset_req,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         cpu_reset,
  output reg         memory_module_reset_n
);

  // ==========================================================
  // timing counts
  localparam integer FILT_RAW = (`SRC_LV_FILTER_NS * `SRC_CLK_MHZ + 999) / 1000;
  localparam integer FILT_INT = (FILT_RAW < 1) ? 1 : FILT_RAW;
  localparam [7:0]   FILT_CYCLES = FILT_INT[7:0];
  localparam [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_CYCLES[STRETCH_W-1:0];
  // full-width rollover value, cut to the counter width on purpose
  localparam [23:0]          WD_MAX_FULL = `SRC_WD_COUNT_MAX;
  localparam [WD_W-1:0]      WD_MAX = WD_MAX_FULL[WD_W-1:0];

  // ==========================================================
  // address decode
  function sel;
    input [4:0] a;
    input [4:0] o;
    begin
      sel = (a[4:2] == o[4:2]);
    end
  endfunction

  // ==========================================================
  // declarations
  wire                 pin_n_s;
  wire                 lv_s;
  reg  [7:0]           lv_cnt;
  reg                  lv_filt;
  reg                  low_voltage_reset_disable;
  reg                  por_flag;
  reg                  debug_en;
  reg  [3:0]           cause;
  reg  [7:0]           watchdog_key;
  reg  [7:0]           watchdog_reload;
  reg  [WD_W-1:0]      wd_cnt;
  reg  [1:0]           mc_div;
  reg                  wd_ovf;
  reg  [STRETCH_W-1:0] stretch_cnt;
  reg  [31:0]          next_readdata;
  wire                 wr_ok;
  wire                 rd_take;
  wire                 wd_en;
  wire                 src_ext;
  wire                 src_lv;
  wire                 src_wd;
  wire                 src_dbg;
  wire                 any_src;
  wire                 wr_pwr;
  wire                 wr_key;
  wire                 wr_reload;
  wire                 wr_dbg;
  wire                 wr_cause;
  wire                 stretch_busy;
  wire                 next_cpu_reset;

  // ==========================================================
  // input synchronisers
  // sync reset pin
  src_sync2 #(
    .RST_VAL (1'b0)
  ) u_sync_pin (
    .clk  (clk),
    .nrst (nrst),
    .d    (reset_pin_n),
    .q    (pin_n_s)
  );

  src_sync2 #(
    .RST_VAL (1'b0)
  ) u_sync_lv (
    .clk  (clk),
    .nrst (nrst),
    .d    (low_voltage_in),
    .q    (lv_s)
  );

  // ==========================================================
  // bus handshake
  // one wait cycle on every access; the answer edge is the second edge
  // readdata loads on the taking edge, so it stands at the answer edge
  assign wr_ok     = avs_write & ~avs_waitrequest;
  assign rd_take   = avs_read & avs_waitrequest;
  assign wr_pwr    = wr_ok & sel(avs_address, `SRC_OFS_PWR_CTRL);
  assign wr_key    = wr_ok & sel(avs_address, `SRC_OFS_WD_KEY);
  assign wr_reload = wr_ok & sel(avs_address, `SRC_OFS_WD_RELOAD);
  assign wr_dbg    = wr_ok & sel(avs_address, `SRC_OFS_DEBUG_CTRL);
  assign wr_cause  = wr_ok & sel(avs_address, `SRC_OFS_CAUSE);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  always @* begin
    next_readdata = 32'h0000_0000;
    if (sel(avs_address, `SRC_OFS_PWR_CTRL)) begin
      next_readdata[`SRC_BIT_LV_DISABLE] = low_voltage_reset_disable;
      next_readdata[`SRC_BIT_POR_FLAG]   = por_flag;
    end else if (sel(avs_address, `SRC_OFS_WD_KEY)) begin
      next_readdata[7:0] = watchdog_key;
    end else if (sel(avs_address, `SRC_OFS_WD_RELOAD)) begin
      next_readdata[7:0] = watchdog_reload;
    end else if (sel(avs_address, `SRC_OFS_WD_COUNT)) begin
      next_readdata[WD_W-1:0] = wd_cnt;
    end else if (sel(avs_address, `SRC_OFS_DEBUG_CTRL)) begin
      next_readdata[`SRC_BIT_DEBUG_EN] = debug_en;
    end else if (sel(avs_address, `SRC_OFS_CAUSE)) begin
      next_readdata[3:0] = cause;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= next_readdata;
    end
  end

  // ==========================================================
  // low-voltage glitch filter
  // glitch filter count
  // dropout clears at once; the stretch supplies the hold-off
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lv_cnt  <= 8'h00;
      lv_filt <= 1'b0;
    end else if (!lv_s) begin
      lv_cnt  <= 8'h00;
      lv_filt <= 1'b0;
    end else if (lv_cnt != FILT_CYCLES) begin
      lv_cnt  <= lv_cnt + 8'h01;
    end else begin
      lv_filt <= 1'b1;
    end
  end

  // ==========================================================
  // reset sources
  // no mode gating
  // nothing here looks at idle or power-down, so the detector path stays live
  assign src_ext = ~pin_n_s;
  assign src_lv  = lv_filt & ~low_voltage_reset_disable;
  assign src_wd  = wd_ovf;
  assign src_dbg = debug_reset_req & debug_en;
  assign any_src = src_ext | src_lv | src_wd | src_dbg;

  // ==========================================================
  // reset stretch
  // a source or a running stretch keeps the reset asserted
  assign stretch_busy   = (stretch_cnt != {STRETCH_W{1'b0}});
  assign next_cpu_reset = any_src | stretch_busy;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stretch_cnt           <= STRETCH_LOAD;
      cpu_reset             <= 1'b1;
      memory_module_reset_n <= 1'b0;
    end else begin
      if (any_src) begin
        stretch_cnt <= STRETCH_LOAD;
      end else if (stretch_busy) begin
        stretch_cnt <= stretch_cnt - {{(STRETCH_W-1){1'b0}}, 1'b1};
      end
      cpu_reset             <= next_cpu_reset;
      memory_module_reset_n <= ~next_cpu_reset;
    end
  end

  // ==========================================================
  // power control, debug control and cause flags
  // the power control bit returns to default on every internal reset; debug_en and the flags do not
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_voltage_reset_disable <= 1'b0;
    end else if (cpu_reset) begin
      low_voltage_reset_disable <= 1'b0;
    end else if (wr_pwr) begin
      low_voltage_reset_disable <= avs_writedata[`SRC_BIT_LV_DISABLE];
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_flag <= 1'b1;
      debug_en <= 1'b0;
      cause    <= 4'h0;
    end else begin
      por_flag <= src_lv | (por_flag & ~(wr_pwr & ~avs_writedata[`SRC_BIT_POR_FLAG]));
      if (wr_dbg) begin
        debug_en <= avs_writedata[`SRC_BIT_DEBUG_EN];
      end
      // write one clears; a new event in the same cycle wins
      cause <= ({src_dbg, src_wd, src_lv, src_ext})
             | (cause & ~(wr_cause ? avs_writedata[3:0] : 4'h0));
    end
  end

  // ==========================================================
  // watchdog
  assign wd_en = (watchdog_key != `SRC_WD_KEY_OFF);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_key    <= `SRC_WD_KEY_RESET;
      watchdog_reload <= `SRC_WD_RELOAD_RESET;
      wd_cnt          <= {WD_W{1'b0}};
      mc_div          <= 2'h0;
      wd_ovf          <= 1'b0;
    end else if (cpu_reset) begin
      watchdog_key    <= `SRC_WD_KEY_RESET;
      watchdog_reload <= `SRC_WD_RELOAD_RESET;
      wd_cnt          <= {WD_W{1'b0}};
      mc_div          <= 2'h0;
      wd_ovf          <= 1'b0;
    end else begin
      wd_ovf <= 1'b0;
      if (wr_key) begin
        watchdog_key <= avs_writedata[7:0];
      end
      if (wr_reload) begin
        watchdog_reload <= avs_writedata[7:0];
      end
      if (!wd_en) begin
        wd_cnt <= {WD_W{1'b0}};
        mc_div <= 2'h0;
      end else if (wr_reload) begin
        wd_cnt <= {avs_writedata[7:0], {(WD_W-8){1'b0}}};
      end else begin
        mc_div <= mc_div + 2'h1;
        if (mc_div == `SRC_MC_LAST) begin
          wd_cnt <= wd_cnt + {{(WD_W-1){1'b0}}, 1'b1};
          if (wd_cnt == WD_MAX) begin
            wd_ovf <= 1'b1;
          end
        end
      end
    end
  end

endmodule // src_supervisor

// ### hdl/src_consts.vh
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH

// ==========================================================
// register byte offsets on the avalon slave
`define SRC_OFS_PWR_CTRL     5'h00
`define SRC_OFS_WD_KEY       5'h04
`define SRC_OFS_WD_RELOAD    5'h08
`define SRC_OFS_WD_COUNT     5'h0C
`define SRC_OFS_DEBUG_CTRL   5'h10
`define SRC_OFS_CAUSE        5'h14

// ==========================================================
// field positions
`define SRC_BIT_LV_DISABLE   5
`define SRC_BIT_POR_FLAG     4
`define SRC_BIT_DEBUG_EN     0
`define SRC_BIT_CAUSE_EXT    0
`define SRC_BIT_CAUSE_LV     1
`define SRC_BIT_CAUSE_WD     2
`define SRC_BIT_CAUSE_DBG    3

// ==========================================================
// reset values and codes
`define SRC_WD_KEY_RESET     8'h55
`define SRC_WD_KEY_OFF       8'h55
`define SRC_WD_RELOAD_RESET  8'h00
`define SRC_WD_COUNT_MAX     24'hFF_FFFF
`define SRC_MC_LAST          2'h3

// ==========================================================
// timing
`define SRC_CLK_MHZ          200
`define SRC_LV_FILTER_NS     1000
`define SRC_STRETCH_MS       10
`define SRC_STRETCH_REF_KHZ  40000

`endif

// ### hdl/src_sync2.v
// ==========================================================
// two-flop synchroniser, first stage read only by the second
module src_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire nrst,
  input  wire d,
  output reg  q
);

  reg meta;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // src_sync2

// ### tb/src_reset_sink.sv
// ==========================================================
// processor core and memory module reset inputs
module src_reset_sink (
  input  logic       clk,
  input  logic       cpu_reset,
  input  logic       memory_module_reset_n,
  output logic [7:0] releases
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       held = 1'b0;
  logic [7:0] count = 8'h00;
  assign releases = count;
  always @(posedge clk) begin
    if (held && !cpu_reset && memory_module_reset_n) count <= count + 8'h01;
    held <= cpu_reset;
  end
endmodule // src_reset_sink

// ### tb/src_supervisor_assertions.sv
// ==========================================================
// port checker
module src_sva #(parameter int STRETCH_CYCLES = 20) (
  input logic        clk,
  input logic        nrst,
  input logic        reset_pin_n,
  input logic        low_voltage_in,
  input logic        debug_reset_req,
  input logic [4:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        cpu_reset,
  input logic        memory_module_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int since_pin;
  int quiet;
  // quiet restarts on any raw source, so ignored sources only loosen it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_pin <= 0;
      quiet     <= 0;
    end else begin
      since_pin <= !reset_pin_n ? 0 : since_pin + 1;
      quiet <= (!reset_pin_n || low_voltage_in || debug_reset_req || !cpu_reset) ? 0 : quiet + 1;
    end
  end
  sequence pin_held;
    !reset_pin_n [*3];
  endsequence
  sequence answer_cycle;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  rst_pair_a: assert property (memory_module_reset_n == !cpu_reset)
    else $error("memory reset not inverse of cpu reset");
  ext_pin_a: assert property (pin_held |-> ##[0:3] cpu_reset)
    else $error("pin reset not seen");
  stretch_min_a: assert property ($fell(cpu_reset) |-> since_pin >= STRETCH_CYCLES)
    else $error("reset released early");
  stretch_max_a: assert property (quiet <= STRETCH_CYCLES + 8)
    else $error("reset held too long");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##1 answer_cycle)
    else $error("bus answer not one wait cycle");
  wait_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer without request");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[4:2] > 3'h5
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
    else $error("read data moved outside answer");
endmodule // src_sva

bind src_supervisor src_sva #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_sva (.clk(clk), .nrst(nrst),
  .reset_pin_n(reset_pin_n), .low_voltage_in(low_voltage_in), .debug_reset_req(debug_reset_req),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_reset(cpu_reset),
  .memory_module_reset_n(memory_module_reset_n));

// ### tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reset_pin_n = 1'b0;
  logic        low_voltage_in = 1'b0;
  logic        debug_reset_req = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cpu_reset;
  logic        memory_module_reset_n;
  logic [7:0]  releases;
  logic [7:0]  key;
  logic [63:0] exp_q[$];
  int          num_errors = 0;
  int          num_checks = 0;

  always #2.5 clk = ~clk;

  // short stretch and a 16-bit watchdog keep the run brief
  src_supervisor #(.STRETCH_CYCLES(20), .WD_W(16)) uut (.clk(clk), .nrst(nrst),
    .reset_pin_n(reset_pin_n), .low_voltage_in(low_voltage_in),
    .debug_reset_req(debug_reset_req), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_reset(cpu_reset),
    .memory_module_reset_n(memory_module_reset_n));
  src_reset_sink u_sink (.clk(clk), .cpu_reset(cpu_reset),
    .memory_module_reset_n(memory_module_reset_n), .releases(releases));

  // ==========================================================
  // checks
  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [63:0] e);
    num_checks++;
    if ((got & e[63:32]) !== (e[31:0] & e[63:32])) fail("read data mismatch");
  endtask
  task automatic chk_rst(input logic e);
    num_checks++;
    if (cpu_reset !== e) fail("reset level mismatch");
  endtask
  task automatic chk_count(input logic [7:0] got, input logic [7:0] e);
    num_checks++;
    if (got !== e) fail("reset release count");
  endtask
  task automatic wait_rst(input logic e, input int n);
    int i;
    i = 0;
    while (cpu_reset !== e && i < n) begin
      @(posedge clk);
      i++;
    end
    chk_rst(e);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // bus master
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    // no cycle budget here: only the 100us run timeout ends a wait
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) fail("read with no note");
      else chk_data(avs_readdata, exp_q.pop_front());
    end
  end

  initial begin
    #100us;
    fail("run hung");
    stop_test;
  end

  // ==========================================================
  // tests
  initial begin
    void'($urandom(40));
    repeat (10) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_rst(1'b0, 40);
    rd(5'h00, 32'h0000_0010, '1);
    rd(5'h04, 32'h0000_0055, '1);
    rd(5'h08, 32'h0000_0000, '1);
    rd(5'h0C, 32'h0000_0000, '1);
    bus(1'b1, 5'h18, 32'hFFFF_FFFF);
    rd(5'h18, 32'h0000_0000, '1);
    bus(1'b1, 5'h00, 32'h0000_0020);
    rd(5'h00, 32'h0000_0020, '1);
    low_voltage_in <= 1'b1;
    repeat (300) @(posedge clk);
    chk_rst(1'b0);
    low_voltage_in <= 1'b0;
    // let the filtered level drain before re-arming, or it trips a reset
    repeat (5) @(posedge clk);
    bus(1'b1, 5'h00, 32'h0000_0000);
    low_voltage_in <= 1'b1;
    repeat (50 + $urandom_range(99)) @(posedge clk);
    low_voltage_in <= 1'b0;
    repeat (10) @(posedge clk);
    chk_rst(1'b0);
    low_voltage_in <= 1'b1;
    wait_rst(1'b1, 260);
    repeat (50) @(posedge clk);
    chk_rst(1'b1);
    low_voltage_in <= 1'b0;
    wait_rst(1'b0, 40);
    rd(5'h00, 32'h0000_0010, '1);
    reset_pin_n <= 1'b0;
    wait_rst(1'b1, 6);
    reset_pin_n <= 1'b1;
    wait_rst(1'b0, 40);
    debug_reset_req <= 1'b1;
    repeat (30) @(posedge clk);
    chk_rst(1'b0);
    debug_reset_req <= 1'b0;
    bus(1'b1, 5'h10, 32'h0000_0001);
    debug_reset_req <= 1'b1;
    wait_rst(1'b1, 5);
    debug_reset_req <= 1'b0;
    wait_rst(1'b0, 40);
    bus(1'b1, 5'h10, 32'h0000_0000);
    key = 8'($urandom_range(255));
    if (key == 8'h55) key = 8'h56;
    bus(1'b1, 5'h04, {24'h00_0000, key});
    bus(1'b1, 5'h08, 32'h0000_00FF);
    rd(5'h0C, 32'h0000_FF00, 32'h0000_FF00);
    bus(1'b1, 5'h04, 32'h0000_0055);
    rd(5'h0C, 32'h0000_0000, '1);
    bus(1'b1, 5'h04, {24'h00_0000, key});
    bus(1'b1, 5'h08, 32'h0000_00FF);
    repeat (600) @(posedge clk);
    bus(1'b1, 5'h08, 32'h0000_00FF);
    repeat (600) @(posedge clk);
    chk_rst(1'b0);
    wait_rst(1'b1, 500);
    wait_rst(1'b0, 40);
    rd(5'h04, 32'h0000_0055, '1);
    rd(5'h0C, 32'h0000_0000, '1);
    rd(5'h14, 32'h0000_000F, '1);
    bus(1'b1, 5'h14, 32'h0000_000F);
    rd(5'h14, 32'h0000_0000, '1);
    chk_count(releases, 8'h05);
    stop_test;
  end
endmodule // testbench
